/* src/cts_cfg.svh */
// Constants for the processor timer set: offsets, fields, rates.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH

// Clock rates in Hz and the derived divider counts
`define CTS_CORE_HZ 100000000
`define CTS_RC_HZ 2000000
`define CTS_RC_DIV (`CTS_CORE_HZ / `CTS_RC_HZ)
`define CTS_SLEEP_DIV 64

// Dual timer register offsets (byte addresses, one word each)
`define CTS_BASE1 8'h10
`define CTS_OFF_LOAD 4'h0
`define CTS_OFF_VALUE 4'h4
`define CTS_OFF_CTRL 4'h8
`define CTS_OFF_CLR 4'hC

// Control register fields
`define CTS_CTRL_EN 0
`define CTS_CTRL_MODE_LO 1
`define CTS_CTRL_MODE_HI 2
`define CTS_CTRL_IRQ 3

// Reset and wrap values
`define CTS_ZERO32 32'h0000_0000
`define CTS_ONES32 32'hFFFF_FFFF

`endif

/* src/cts_down_ctr.sv */
// One 32-bit down-counter with free, periodic and one-shot behaviour.
// Assumes one core clock; step_en is a one-cycle advance pulse.
`timescale 1ns/1ps
`include "cts_cfg.svh"

module cts_down_ctr
    import cts_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic step_en,
    input wire logic enable,
    input wire cts_mode_t mode,
    input wire logic [31:0] load_val,
    input wire logic load_wr,
    input wire logic irq_clr,
    // Status
    output logic [31:0] count,
    output logic irq,
    output logic expire
);

    typedef struct packed {
        logic [31:0] cnt;
        logic run;
        logic irq;
    } cts_ctr_state_t;

    cts_ctr_state_t st_reg;
    cts_ctr_state_t st_next;
    logic adv;

    // Next state of count, run flag and sticky interrupt
    always_comb begin
        st_next = st_reg;
        expire = 1'b0;
        adv = step_en && enable && st_reg.run;
        if (load_wr) begin
            st_next.cnt = load_val;
            st_next.run = 1'b1; // Reprogramming restarts a halted count
        end else if (adv) begin
            if (st_reg.cnt == 32'h0000_0001 ||
                (st_reg.cnt == `CTS_ZERO32 && mode == CTS_ONESHOT)) begin
                expire = 1'b1; // Expiry on reaching zero
                case (mode)
                    CTS_PERIODIC: st_next.cnt = load_val;
                    CTS_ONESHOT: begin
                        st_next.cnt = `CTS_ZERO32;
                        st_next.run = 1'b0; // Halt after one expiry
                    end
                    default: st_next.cnt = `CTS_ZERO32;
                endcase
            end else if (st_reg.cnt == `CTS_ZERO32) begin
                // Free wraps to all ones, periodic reloads
                st_next.cnt = (mode == CTS_PERIODIC) ? load_val
                                                      : `CTS_ONES32;
            end else begin
                st_next.cnt = st_reg.cnt - 32'h0000_0001;
            end
        end
        // Sticky flag, a new expiry wins over a clear
        if (irq_clr) begin
            st_next.irq = 1'b0;
        end
        if (expire) begin
            st_next.irq = 1'b1;
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count = st_reg.cnt;
    assign irq = st_reg.irq;

endmodule : cts_down_ctr

/* src/cts_pkg.sv */
// Types shared by the processor timer set modules.
// Assumes the constants header is on the include path.
`include "cts_cfg.svh"

package cts_pkg;

    // Counter behaviour after reaching zero
    typedef enum logic [1:0] {
        CTS_FREE,
        CTS_PERIODIC,
        CTS_ONESHOT
    } cts_mode_t;

    // Decode of the two mode bits; the spare code acts as one-shot
    function automatic cts_mode_t cts_mode_of(input logic [1:0] bits);
        case (bits)
            2'h0: cts_mode_of = CTS_FREE;
            2'h1: cts_mode_of = CTS_PERIODIC;
            default: cts_mode_of = CTS_ONESHOT;
        endcase
    endfunction : cts_mode_of

endpackage : cts_pkg

/* src/cts_timer_set.sv */
// Processor timer set: interval tick timer, APB dual timer, wake timer.
// Assumes a 100 MHz core clock and the sleep rate derived from it.
//
// Operation
// - A 32-bit timer gives a recurring tick at a programmed interval.
// - The dual timer has two independent 32-bit down-counters.
// - Each dual-timer counter raises its own interrupt on expiry.
// - Each dual counter runs free, periodic with reload, or one-shot.
// - The dual timer is programmed and read as an APB slave.
// - The wake timer is a 32-bit down-counter on the ~32 kHz sleep rate.
// - Wake timer expiry gives a processor interrupt and a chip wake-up.
// - In one-time mode the wake timer signals once and then stops.
// - In auto-reload mode the wake timer signals and restarts at once.
// - The sleep rate is the 2 MHz RC rate divided by sixty-four.
`timescale 1ns/1ps
`include "cts_cfg.svh"

module cts_timer_set
    import cts_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave for the dual timer
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Dual timer interrupts
    output logic dual0_irq,
    output logic dual1_irq,
    // Interval tick timer
    input wire logic [31:0] tick_load,
    input wire logic tick_load_wr,
    input wire logic tick_enable,
    input wire logic tick_clr,
    output logic tick_pulse,
    output logic tick_irq,
    output logic [31:0] tick_count,
    // Wake timer
    input wire logic [31:0] wake_load,
    input wire logic wake_load_wr,
    input wire logic wake_enable,
    input wire logic wake_auto,
    input wire logic wake_clr,
    output logic wake_irq,
    output logic chip_wake,
    output logic [31:0] wake_count
);

    typedef struct packed {
        logic [31:0] rdata;
        logic [1:0] en;
        logic [1:0] mode0;
        logic [1:0] mode1;
        logic [31:0] load0;
        logic [31:0] load1;
        logic [5:0] rc_cnt;
        logic [5:0] sleep_cnt;
        logic [31:0] tick_val;
        logic [31:0] wake_val;
    } cts_top_state_t;

    cts_top_state_t st_reg;
    cts_top_state_t st_next;

    logic [1:0] d_load_wr;
    logic [1:0] d_clr;
    logic [1:0] d_irq;
    logic [31:0] d_cnt0;
    logic [31:0] d_cnt1;
    logic rc_en;
    logic sleep_en;
    logic setup_rd;
    logic access_wr;
    logic sel1;
    logic [3:0] reg_off;
    logic mapped;
    logic tick_irq_i;
    logic tick_exp;
    logic wake_irq_i;
    logic [31:0] tick_cnt_i;
    logic [31:0] wake_cnt_i;

    // Address decode of the two register banks
    assign sel1 = (paddr[7:4] == 4'(`CTS_BASE1 >> 4));
    assign reg_off = paddr[3:0];
    assign mapped = (paddr[7:4] == 4'h0) || sel1;
    assign setup_rd = psel && !penable && !pwrite;
    assign access_wr = psel && penable && pwrite && mapped;

    // Write strobes to each counter
    always_comb begin
        d_load_wr = 2'h0;
        d_clr = 2'h0;
        if (access_wr && reg_off == `CTS_OFF_LOAD) begin
            d_load_wr[sel1] = 1'b1;
        end
        if (access_wr && reg_off == `CTS_OFF_CLR) begin
            d_clr[sel1] = 1'b1;
        end
    end

    // Dividers: core to 2 MHz, then 2 MHz by sixty-four
    assign rc_en = (st_reg.rc_cnt == 6'(`CTS_RC_DIV - 1));
    assign sleep_en = rc_en && (st_reg.sleep_cnt == 6'(`CTS_SLEEP_DIV - 1));

    // Register updates and read data capture
    always_comb begin
        st_next = st_reg;
        st_next.rc_cnt = rc_en ? 6'h00 : st_reg.rc_cnt + 6'h01;
        if (rc_en) begin
            st_next.sleep_cnt = st_reg.sleep_cnt + 6'h01; // Wraps at 64
        end
        if (access_wr && reg_off == `CTS_OFF_LOAD) begin
            if (sel1) begin
                st_next.load1 = pwdata;
            end else begin
                st_next.load0 = pwdata;
            end
        end
        if (access_wr && reg_off == `CTS_OFF_CTRL) begin
            st_next.en[sel1] = pwdata[`CTS_CTRL_EN];
            if (sel1) begin
                st_next.mode1 = pwdata[`CTS_CTRL_MODE_HI:`CTS_CTRL_MODE_LO];
            end else begin
                st_next.mode0 = pwdata[`CTS_CTRL_MODE_HI:`CTS_CTRL_MODE_LO];
            end
        end
        // Read data is sampled in the setup phase
        if (setup_rd) begin
            case (reg_off)
                `CTS_OFF_LOAD: st_next.rdata = sel1 ? st_reg.load1
                                                    : st_reg.load0;
                `CTS_OFF_VALUE: st_next.rdata = sel1 ? d_cnt1 : d_cnt0;
                `CTS_OFF_CTRL: begin
                    st_next.rdata = `CTS_ZERO32;
                    st_next.rdata[`CTS_CTRL_EN] = st_reg.en[sel1];
                    st_next.rdata[`CTS_CTRL_MODE_HI:`CTS_CTRL_MODE_LO] =
                        sel1 ? st_reg.mode1 : st_reg.mode0;
                    st_next.rdata[`CTS_CTRL_IRQ] = d_irq[sel1];
                end
                default: st_next.rdata = `CTS_ZERO32;
            endcase
            if (!mapped) begin
                st_next.rdata = `CTS_ZERO32;
            end
        end
        st_next.tick_val = tick_cnt_i;
        st_next.wake_val = wake_cnt_i;
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Two independent dual-timer counters on the core clock
    cts_down_ctr u_dual0 (
        .core_clk(core_clk),
        .rst(rst),
        .step_en(1'b1),
        .enable(st_reg.en[0]),
        .mode(cts_mode_of(st_reg.mode0)),
        .load_val(d_load_wr[0] ? pwdata : st_reg.load0),
        .load_wr(d_load_wr[0]),
        .irq_clr(d_clr[0]),
        .count(d_cnt0),
        .irq(d_irq[0]),
        .expire()
    );

    cts_down_ctr u_dual1 (
        .core_clk(core_clk),
        .rst(rst),
        .step_en(1'b1),
        .enable(st_reg.en[1]),
        .mode(cts_mode_of(st_reg.mode1)),
        .load_val(d_load_wr[1] ? pwdata : st_reg.load1),
        .load_wr(d_load_wr[1]),
        .irq_clr(d_clr[1]),
        .count(d_cnt1),
        .irq(d_irq[1]),
        .expire()
    );

    // Interval tick timer, always periodic
    cts_down_ctr u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .step_en(1'b1),
        .enable(tick_enable),
        .mode(CTS_PERIODIC),
        .load_val(tick_load),
        .load_wr(tick_load_wr),
        .irq_clr(tick_clr),
        .count(tick_cnt_i),
        .irq(tick_irq_i),
        .expire(tick_exp)
    );

    // Wake timer on the sleep rate, one-time or auto-reload
    cts_down_ctr u_wake (
        .core_clk(core_clk),
        .rst(rst),
        .step_en(sleep_en),
        .enable(wake_enable),
        .mode(wake_auto ? CTS_PERIODIC : CTS_ONESHOT),
        .load_val(wake_load),
        .load_wr(wake_load_wr),
        .irq_clr(wake_clr),
        .count(wake_cnt_i),
        .irq(wake_irq_i),
        .expire()
    );

    // APB answers: no wait states, error on an unmapped address
    assign prdata = st_reg.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Interrupt and wake outputs
    assign dual0_irq = d_irq[0];
    assign dual1_irq = d_irq[1];
    assign tick_pulse = tick_exp;
    assign tick_irq = tick_irq_i;
    assign tick_count = st_reg.tick_val;
    assign wake_irq = wake_irq_i;
    assign chip_wake = wake_irq_i;
    assign wake_count = st_reg.wake_val;

endmodule : cts_timer_set

/* tb/cts_timer_set_bench.sv */
// Self-checking bench for the processor timer set.
// Assumes design, package and checker are compiled first.
`timescale 1ns/1ps

module cts_timer_set_bench
    import cts_pkg::*;
;
    // Bench-side drives and observed outputs
    logic core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, tick_load_wr = 1'h0, tick_enable = 1'h0;
    logic tick_clr = 1'h0, wake_load_wr = 1'h0, wake_enable = 1'h0;
    logic wake_auto = 1'h0, wake_clr = 1'h0, er;
    logic [7:0] paddr = 8'h00, b;
    logic [31:0] pwdata = 32'h0000_0000, tick_load = 32'h0000_0000;
    logic [31:0] wake_load = 32'h0000_0000, rd, prdata, tick_count;
    logic [31:0] wake_count;
    logic pready, pslverr, dual0_irq, dual1_irq, tick_pulse, tick_irq;
    logic wake_irq, chip_wake, mine, peer;
    int err_total = 0, checks_done = 0, cyc = 0, n;
    // Dual timer cases: bank base, mode, refire, value zero, value top
    typedef struct packed {
        logic [7:0] base;
        logic [1:0] mode;
        logic rep, zero, hi;
    } cts_row_t;
    cts_row_t rows [4] = '{'{8'h00, 2'h0, 1'h0, 1'h0, 1'h1},
        '{8'h10, 2'h1, 1'h1, 1'h0, 1'h0}, '{8'h00, 2'h2, 1'h0, 1'h1, 1'h0},
        '{8'h10, 2'h3, 1'h0, 1'h1, 1'h0}};

    cts_timer_set cts_timer_set_inst (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dual0_irq(dual0_irq), .dual1_irq(dual1_irq),
        .tick_load(tick_load), .tick_load_wr(tick_load_wr),
        .tick_enable(tick_enable), .tick_clr(tick_clr),
        .tick_pulse(tick_pulse), .tick_irq(tick_irq),
        .tick_count(tick_count), .wake_load(wake_load),
        .wake_load_wr(wake_load_wr), .wake_enable(wake_enable),
        .wake_auto(wake_auto), .wake_clr(wake_clr), .wake_irq(wake_irq),
        .chip_wake(chip_wake), .wake_count(wake_count));

    // Flag of the bank under test and of the other bank
    assign mine = b[4] ? dual1_irq : dual0_irq;
    assign peer = b[4] ? dual0_irq : dual1_irq;

    // Clock and hang limit
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            results();
        end
    end

    task results;
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Lands just after an edge
    task step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step

    // One bus transfer, then an idle cycle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel = 1'h1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        step(1);
        penable = 1'h1;
        @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        #1;
        psel = 1'h0;
        penable = 1'h0;
        step(1);
    endtask : apb

    // Wake timer run with load 2 in the given mode
    task wk(input logic a);
        wake_auto = a;
        wake_load = 32'h0000_0002;
        wake_load_wr = 1'h1;
        wake_enable = 1'h1;
        step(1);
        wake_load_wr = 1'h0;
        step(3100);
        chk("wake early", 32'h0, {31'h0, wake_irq});
        step(6500);
        chk("chip wake", 32'h1, {31'h0, chip_wake});
        wake_clr = 1'h1;
        step(1);
        wake_clr = 1'h0;
        step(9700);
        chk("wake again", {31'h0, a}, {31'h0, wake_irq});
        chk("wake rest", {31'h0, !a}, {31'h0, wake_count == 0});
    endtask : wk

    // Main sequence
    initial begin
        step(3);
        chk("ready in reset", 32'h1, {31'h0, pready});
        chk("tick in reset", 32'h0, {31'h0, tick_irq});
        step(1);
        rst = 1'h0;
        apb(1'h0, 8'h08, 32'h0000_0000);
        chk("ctrl reset", 32'h0, rd);
        chk("mapped err", 32'h0, {31'h0, er});
        foreach (rows[i]) begin
            b = rows[i].base;
            // Load while stopped, then start, so no old count expires
            apb(1'h1, b, 32'h0000_0014);
            apb(1'h1, b + 8'h08, {29'h0, rows[i].mode, 1'h1});
            step(16);
            chk("irq early", 32'h0, {31'h0, mine});
            step(6);
            chk("irq", 32'h1, {31'h0, mine});
            chk("other", 32'h0, {31'h0, peer});
            apb(1'h0, b + 8'h08, 32'h0000_0000);
            chk("ctrl irq", 32'h1, {31'h0, rd[3]});
            apb(1'h1, b + 8'h0C, 32'h0000_0000);
            chk("cleared", 32'h0, {31'h0, mine});
            step(24);
            chk("refire", {31'h0, rows[i].rep}, {31'h0, mine});
            apb(1'h0, b + 8'h04, 32'h0000_0000);
            chk("value zero", {31'h0, rows[i].zero}, {31'h0, ~|rd});
            chk("value top", {31'h0, rows[i].hi}, {31'h0, rd[31]});
            apb(1'h1, b + 8'h08, 32'h0000_0000);
            apb(1'h1, b + 8'h0C, 32'h0000_0000);
        end
        // Unmapped place refused
        apb(1'h1, 8'h40, 32'hFFFF_FFFF);
        chk("wr err", 32'h1, {31'h0, er});
        apb(1'h0, 8'h40, 32'h0000_0000);
        chk("rd unmapped", 32'h0, rd);
        // Tick timer period 5 over 30 cycles
        tick_load = 32'h0000_0005;
        tick_load_wr = 1'h1;
        tick_enable = 1'h1;
        step(1);
        tick_load_wr = 1'h0;
        n = 0;
        repeat (30) begin
            step(1);
            n += tick_pulse;
        end
        chk("ticks", 32'h6, n);
        tick_enable = 1'h0;
        step(1);
        tick_clr = 1'h1;
        step(1);
        tick_clr = 1'h0;
        step(1);
        chk("tick clr", 32'h0, {31'h0, tick_irq});
        chk("tick count", 32'h0000_0005, tick_count);
        wk(1'h0);
        wk(1'h1);
        // Reset in mid-run clears flags and counts
        rst = 1'h1;
        step(2);
        chk("wake rst", 32'h0, {31'h0, chip_wake});
        chk("tick cnt rst", 32'h0, tick_count);
        rst = 1'h0;
        step(2);
        chk("wake after rst", 32'h0, {31'h0, wake_irq});
        chk("dual rst", 32'h0, {30'h0, dual1_irq, dual0_irq});
        results();
    end
endmodule : cts_timer_set_bench

/* tb/cts_timer_set_chk.sv */
// Port checker for the processor timer set.
// Assumes it is bound onto cts_timer_set with one core clock.
`timescale 1ns/1ps

module cts_timer_set_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bus side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Timer side
    input wire logic dual0_irq,
    input wire logic dual1_irq,
    input wire logic tick_enable,
    input wire logic tick_clr,
    input wire logic tick_pulse,
    input wire logic tick_irq,
    input wire logic wake_clr,
    input wire logic wake_irq,
    input wire logic chip_wake
);
    // One clock domain for every property
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Bus answers and refusals
    property p_rdy; pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready dropped");
    property p_err;
        pslverr == (psel && penable && paddr[7:5] != 3'h0);
    endproperty
    a_err: assert property (p_err) else $error("bad error flag");
    // Tick timer expiry and sticky flag
    property p_tset; tick_pulse |=> tick_irq; endproperty
    a_tset: assert property (p_tset) else $error("tick flag not set");
    property p_tpul; tick_pulse |-> tick_enable; endproperty
    a_tpul: assert property (p_tpul) else $error("tick while off");
    property p_thold; tick_irq && !tick_clr |=> tick_irq; endproperty
    a_thold: assert property (p_thold) else $error("tick flag lost");
    property p_tclr; tick_clr && !tick_pulse |=> !tick_irq; endproperty
    a_tclr: assert property (p_tclr) else $error("tick flag kept");
    // Wake timer outputs
    property p_wake; chip_wake == wake_irq; endproperty
    a_wake: assert property (p_wake) else $error("wake mismatch");
    property p_whold; wake_irq && !wake_clr |=> wake_irq; endproperty
    a_whold: assert property (p_whold) else $error("wake flag lost");
    // Dual timer flag held until a clear write
    property p_dhold;
        dual0_irq && !(psel && penable && pwrite && paddr == 8'h0C)
            |=> dual0_irq;
    endproperty
    a_dhold: assert property (p_dhold) else $error("dual flag lost");

    // Main scenarios reached
    c_tick: cover property (tick_pulse);
    c_dual: cover property (dual1_irq);
    c_wake: cover property (chip_wake);
endmodule : cts_timer_set_chk

bind cts_timer_set cts_timer_set_chk cts_timer_set_chk_inst (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .dual0_irq(dual0_irq), .dual1_irq(dual1_irq),
    .tick_enable(tick_enable), .tick_clr(tick_clr),
    .tick_pulse(tick_pulse), .tick_irq(tick_irq), .wake_clr(wake_clr),
    .wake_irq(wake_irq), .chip_wake(chip_wake));
